// ### dphp_device_end.sv
// display end of the parallel host port, with its receive fifo
// Notes on behaviour
// - busy rises on accepted byte, falls when ready
// - busy on status bit 7 and own pin
// - register select: high data, low command/status
// - status read: busy bit 7, cursor bits 0-6
// - host settles select and direction before strobe
// - write data captured as the write strobe ends (E falling, wr_n rising)
// - host checks busy before each byte
// - wide mode takes a byte per strobe
// - narrow mode: upper lines, two writes per byte
// - host sends high nibble first, then low
// - no busy between nibbles, only after byte
// - host waits before status read after width change
// - two strobe styles, enable style is default
// - width command 20h narrow, 30h wide
// - reset starts in wide mode, no init needed

module dphp_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  // depth must be a power of two; pointers wrap naturally
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic valid;
    logic [W-1:0] head;
  } dphp_fifo_st_type;

  dphp_fifo_st_type st;
  dphp_fifo_st_type next_st;
  logic do_wr;
  logic do_rd;

  assign o_in_ready = (st.count != (AW+1)'(DEPTH));
  assign o_out_valid = st.valid;
  assign o_out_data = st.head;

  always_comb
  begin
    next_st = st;
    do_wr = i_in_valid & o_in_ready;
    do_rd = o_out_valid & i_out_ready;
    if (do_wr)
    begin
      next_st.mem[st.wptr] = i_in_data;
      next_st.wptr = st.wptr + 1'b1;
    end
    if (do_rd)
    begin
      next_st.rptr = st.rptr + 1'b1;
    end
    if (do_wr && !do_rd)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (do_rd && !do_wr)
    begin
      next_st.count = st.count - 1'b1;
    end
    // registered head keeps the drain side straight from flip-flops
    next_st.valid = (next_st.count != '0);
    next_st.head = next_st.mem[next_st.rptr];
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule : dphp_fifo

module dphp_device_end
  import dphp_pkg::*;
#(
  parameter int BUSY_CYC = DPHP_BUSY_CYC,
  parameter int FIFO_DEPTH = DPHP_FIFO_DEPTH
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // pins
  dphp_if.device bus,
  // strap: 0 enable style, 1 separate read/write strobes
  input wire logic i_intel_mode,
  // display core side
  input wire logic [6:0] i_cursor_pos,
  input wire logic [7:0] i_read_data,
  output logic o_busy,
  output logic o_narrow,
  output logic o_read_done,
  output logic o_rx_valid,
  output logic o_rx_is_data,
  output logic [7:0] o_rx_byte,
  input wire logic i_rx_ready
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] s_rs;
    logic [1:0] s_rw;
    logic [1:0] s_e;
    logic [1:0] s_rdn;
    logic [1:0] s_wrn;
    logic [1:0] s_intel;
    logic [1:0][7:0] s_d;
    logic wr_act_q;
    logic rd_act_q;
    logic narrow;
    logic nib_pend;
    logic [3:0] hi_nib;
    logic rd_lo;
    logic busy;
    logic [15:0] cnt;
    logic [7:0] dout;
    logic doe;
    logic read_done;
    logic push;
    logic [8:0] push_word;
  } dphp_dev_st_type;

  dphp_dev_st_type st;
  dphp_dev_st_type next_st;
  logic wr_act;
  logic rd_act;
  logic done;
  logic [7:0] b;
  logic [7:0] word;
  logic fifo_ready;
  logic [8:0] fifo_out;

  dphp_fifo #(
    .W(DPHP_FIFO_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(st.push),
    .i_in_data(st.push_word),
    .o_in_ready(fifo_ready),
    .o_out_valid(o_rx_valid),
    .o_out_data(fifo_out),
    .i_out_ready(i_rx_ready)
  );

  assign o_rx_is_data = fifo_out[8];
  assign o_rx_byte = fifo_out[7:0];
  assign o_busy = st.busy;
  assign bus.busy = st.busy;
  assign o_narrow = st.narrow;
  assign o_read_done = st.read_done;
  assign bus.dev_d = st.dout;
  assign bus.dev_oe = st.doe;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    done = 1'b0;
    b = st.s_d[1];
    next_st.s_rs = {st.s_rs[0], bus.register_select};
    next_st.s_rw = {st.s_rw[0], bus.rw};
    next_st.s_e = {st.s_e[0], bus.strobe_e};
    next_st.s_rdn = {st.s_rdn[0], bus.rd_n};
    next_st.s_wrn = {st.s_wrn[0], bus.wr_n};
    next_st.s_intel = {st.s_intel[0], i_intel_mode};
    next_st.s_d = {st.s_d[0], bus.data_bus};
    // both styles fold into one write and one read window
    wr_act = st.s_intel[1] ? ~st.s_wrn[1] : (st.s_e[1] & ~st.s_rw[1]);
    rd_act = st.s_intel[1] ? ~st.s_rdn[1] : (st.s_e[1] & st.s_rw[1]);
    next_st.wr_act_q = wr_act;
    next_st.rd_act_q = rd_act;
    next_st.push = 1'b0;
    next_st.read_done = 1'b0;

    if (st.wr_act_q && !wr_act)
    begin
      if (!st.narrow)
      begin
        done = 1'b1;
      end
      else if (!st.nib_pend)
      begin
        next_st.hi_nib = st.s_d[1][7:4];
        next_st.nib_pend = 1'b1;
      end
      else
      begin
        b = {st.hi_nib, st.s_d[1][7:4]};
        next_st.nib_pend = 1'b0;
        done = 1'b1;
      end
    end

    if (done)
    begin
      next_st.push = 1'b1;
      next_st.push_word = {st.s_rs[1], b};
      next_st.busy = 1'b1;
      next_st.cnt = 16'(BUSY_CYC);
      next_st.rd_lo = 1'b0;
      if (!st.s_rs[1] && dphp_is_cmd(b, DPHP_CMD_NARROW))
      begin
        next_st.narrow = 1'b1;
      end
      else if (!st.s_rs[1] && dphp_is_cmd(b, DPHP_CMD_WIDE))
      begin
        next_st.narrow = 1'b0;
      end
    end
    else if (st.busy)
    begin
      if (st.cnt != '0)
      begin
        next_st.cnt = st.cnt - 16'h0001;
      end
      else if (fifo_ready && !st.push)
      begin
        next_st.busy = 1'b0;
      end
    end

    // status word carries the live busy flag
    word = st.s_rs[1] ? i_read_data : {st.busy, i_cursor_pos};
    if (st.narrow)
    begin
      next_st.dout = st.rd_lo ? {word[3:0], 4'h0} : {word[7:4], 4'h0};
    end
    else
    begin
      next_st.dout = word;
    end
    next_st.doe = rd_act;
    if (st.rd_act_q && !rd_act)
    begin
      next_st.rd_lo = st.narrow & ~st.rd_lo;
      next_st.read_done = st.s_rs[1] & (~st.narrow | st.rd_lo);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st <= '0;
      // idle lines: strobes inactive, read direction
      st.s_rdn <= 2'h3;
      st.s_wrn <= 2'h3;
      st.s_rw <= 2'h3;
      st.narrow <= DPHP_RESET_NARROW;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule : dphp_device_end

// ### dphp_pkg.sv
// shared constants and helpers for the display parallel host port
package dphp_pkg;

  // ----------------------------------------------------------------
  // bus layout
  // ----------------------------------------------------------------
  localparam int DPHP_DW = 8;
  localparam int DPHP_BUSY_BIT = 7;
  localparam int DPHP_FIFO_DEPTH = 32;
  localparam int DPHP_FIFO_W = DPHP_DW + 1;

  // ----------------------------------------------------------------
  // width commands and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] DPHP_CMD_NARROW = 8'h20;
  localparam logic [7:0] DPHP_CMD_WIDE = 8'h30;
  localparam logic [7:0] DPHP_WIDTH_MASK = 8'hfc;
  localparam logic DPHP_RESET_NARROW = 1'b0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int DPHP_CLK_HZ = 20_000_000;
  localparam int DPHP_BUSY_NS = 40_000;
  localparam int DPHP_BUSY_CYC = (DPHP_BUSY_NS * (DPHP_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DPHP_GUARD_NS = 40_000;
  localparam int DPHP_GUARD_CYC = (DPHP_GUARD_NS * (DPHP_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int DPHP_SETUP_CYC = 2;
  localparam int DPHP_PULSE_CYC = 8;
  localparam int DPHP_HOLD_CYC = 8;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic dphp_is_cmd(input logic [7:0] b, input logic [7:0] code);
    dphp_is_cmd = ((b & DPHP_WIDTH_MASK) == code);
  endfunction : dphp_is_cmd

endpackage : dphp_pkg

// ### dphp_if.sv
// pin-level carrier between the host end and the display end
interface dphp_if;
  logic register_select;
  logic rw;
  logic strobe_e;
  logic rd_n;
  logic wr_n;
  logic [7:0] host_d;
  logic host_oe;
  logic [7:0] dev_d;
  logic dev_oe;
  logic busy;
  logic [7:0] data_bus;

  // resolved level of the shared lines; pulled high when nobody drives
  assign data_bus = dev_oe ? dev_d : (host_oe ? host_d : 8'hff);

  modport device (
    input register_select, rw, strobe_e, rd_n, wr_n, data_bus,
    output dev_d, dev_oe, busy
  );

  modport host (
    output register_select, rw, strobe_e, rd_n, wr_n, host_d, host_oe,
    input data_bus, busy
  );
endinterface : dphp_if

// ### dphp_host_end.sv
// host end of the parallel host port: turns requests into bus cycles
module dphp_host_end
  import dphp_pkg::*;
#(
  parameter int GUARD_CYC = DPHP_GUARD_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // pins
  dphp_if.host bus,
  // 0 enable style, 1 separate read/write strobes
  input wire logic i_intel_mode,
  // request
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_rs,
  input wire logic [7:0] i_req_data,
  output logic o_req_ready,
  // answer
  output logic o_rsp_valid,
  output logic [7:0] o_rsp_data,
  output logic o_narrow
);
  typedef enum logic [2:0] {H_IDLE, H_WAIT, H_SETUP, H_STROBE, H_HOLD} dphp_hstate_type;

  typedef struct packed {
    dphp_hstate_type state;
    logic [15:0] cnt;
    logic [15:0] guard;
    logic narrow;
    logic second;
    logic wr;
    logic rs;
    logic [7:0] byte_q;
    logic [3:0] rd_hi;
    logic [1:0] s_busy;
    logic [1:0][7:0] s_d;
    logic pin_rs;
    logic pin_rw;
    logic pin_e;
    logic pin_rdn;
    logic pin_wrn;
    logic [7:0] pin_d;
    logic pin_doe;
    logic req_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
  } dphp_host_st_type;

  dphp_host_st_type st;
  dphp_host_st_type next_st;

  assign bus.register_select = st.pin_rs;
  assign bus.rw = st.pin_rw;
  assign bus.strobe_e = st.pin_e;
  assign bus.rd_n = st.pin_rdn;
  assign bus.wr_n = st.pin_wrn;
  assign bus.host_d = st.pin_d;
  assign bus.host_oe = st.pin_doe;
  assign o_req_ready = st.req_ready;
  assign o_rsp_valid = st.rsp_valid;
  assign o_rsp_data = st.rsp_data;
  assign o_narrow = st.narrow;

  always_comb
  begin
    next_st = st;
    next_st.s_busy = {st.s_busy[0], bus.busy};
    next_st.s_d = {st.s_d[0], bus.data_bus};
    next_st.rsp_valid = 1'b0;
    if (st.guard != '0)
    begin
      next_st.guard = st.guard - 16'h0001;
    end
    unique case (st.state)
      H_IDLE:
      begin
        if (i_req_valid && st.req_ready)
        begin
          next_st.req_ready = 1'b0;
          next_st.wr = i_req_write;
          next_st.rs = i_req_rs;
          next_st.byte_q = i_req_data;
          next_st.second = 1'b0;
          next_st.state = H_WAIT;
        end
      end
      H_WAIT:
      begin
        // status reads are held off after a width change
        if (!st.s_busy[1] && (st.wr || st.rs || st.guard == '0))
        begin
          next_st.pin_rs = st.rs;
          next_st.pin_rw = ~st.wr;
          next_st.pin_d = st.narrow ? {st.byte_q[7:4], 4'h0} : st.byte_q;
          next_st.pin_doe = st.wr;
          next_st.cnt = 16'(DPHP_SETUP_CYC);
          next_st.state = H_SETUP;
        end
      end
      H_SETUP:
      begin
        if (st.cnt != '0)
        begin
          next_st.cnt = st.cnt - 16'h0001;
        end
        else
        begin
          next_st.pin_e = ~i_intel_mode;
          next_st.pin_wrn = ~(i_intel_mode & st.wr);
          next_st.pin_rdn = ~(i_intel_mode & ~st.wr);
          next_st.cnt = 16'(DPHP_PULSE_CYC);
          next_st.state = H_STROBE;
        end
      end
      H_STROBE:
      begin
        if (st.cnt != '0)
        begin
          next_st.cnt = st.cnt - 16'h0001;
        end
        else
        begin
          if (!st.wr && st.narrow && !st.second)
          begin
            next_st.rd_hi = st.s_d[1][7:4];
          end
          else if (!st.wr)
          begin
            next_st.rsp_data = st.narrow ? {st.rd_hi, st.s_d[1][7:4]} : st.s_d[1];
          end
          next_st.pin_e = 1'b0;
          next_st.pin_wrn = 1'b1;
          next_st.pin_rdn = 1'b1;
          next_st.cnt = 16'(DPHP_HOLD_CYC);
          next_st.state = H_HOLD;
        end
      end
      H_HOLD:
      begin
        if (st.cnt != '0)
        begin
          next_st.cnt = st.cnt - 16'h0001;
        end
        else if (st.narrow && !st.second)
        begin
          // no busy check between the two halves of a byte
          next_st.second = 1'b1;
          next_st.pin_d = {st.byte_q[3:0], 4'h0};
          next_st.cnt = 16'(DPHP_SETUP_CYC);
          next_st.state = H_SETUP;
        end
        else
        begin
          next_st.pin_doe = 1'b0;
          next_st.pin_rw = 1'b1;
          if (st.wr && !st.rs && dphp_is_cmd(st.byte_q, DPHP_CMD_NARROW))
          begin
            next_st.narrow = 1'b1;
            next_st.guard = 16'(GUARD_CYC);
          end
          else if (st.wr && !st.rs && dphp_is_cmd(st.byte_q, DPHP_CMD_WIDE))
          begin
            next_st.narrow = 1'b0;
            next_st.guard = 16'(GUARD_CYC);
          end
          next_st.rsp_valid = ~st.wr;
          next_st.req_ready = 1'b1;
          next_st.state = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st <= '0;
      st.state <= H_IDLE;
      st.narrow <= DPHP_RESET_NARROW;
      st.pin_rw <= 1'b1;
      st.pin_rdn <= 1'b1;
      st.pin_wrn <= 1'b1;
      st.req_ready <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end
endmodule : dphp_host_end

// ### dphp_link_asserts.sv
// concurrent checks on the pin link between the host end and the display end
module dphp_link_asserts #(
  parameter int BUSY_CYC = dphp_pkg::DPHP_BUSY_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // link lines
  input wire logic register_select,
  input wire logic rw,
  input wire logic strobe_e,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic host_oe,
  input wire logic dev_oe,
  input wire logic busy,
  input wire logic [7:0] data_bus
);
  // ----------------------------------------------------------------
  // helper counters
  // ----------------------------------------------------------------
  logic wr_win;
  logic wr_win_q;
  int since_wr;
  int busy_len;

  assign wr_win = (strobe_e && !rw) || !wr_n;

  // since_wr saturates so a long idle spell never wraps into a small value
  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_win_q <= 1'b0;
      since_wr <= 99;
      busy_len <= 0;
    end
    else
    begin
      wr_win_q <= wr_win;
      if (wr_win_q && !wr_win)
        since_wr <= 0;
      else if (since_wr < 99)
        since_wr <= since_wr + 1;
      busy_len <= busy ? busy_len + 1 : 0;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  a_busy_cause: assert property ($rose(busy) |-> since_wr <= 8)
    else $error("busy rose without a recent write strobe");
  a_busy_length: assert property ($fell(busy) |-> busy_len >= BUSY_CYC - 1)
    else $error("busy released before its hold count ran out");
  a_oe_no_clash: assert property (dev_oe |-> !host_oe)
    else $error("both ends drive the data lines");
  a_oe_read_only: assert property ($rose(dev_oe) |-> (strobe_e && rw) || !rd_n)
    else $error("device drove the data lines outside a read strobe");
  a_oe_release: assert property (!(strobe_e || !rd_n) [*5] |-> !dev_oe)
    else $error("device kept driving after the read strobe ended");
  a_wr_not_busy: assert property ($rose(wr_win) |-> !busy)
    else $error("write strobe started while busy");
  a_ctrl_setup: assert property ($rose(strobe_e) || $fell(rd_n) || $fell(wr_n)
    |-> $stable(rw) && $stable(register_select))
    else $error("select or direction moved at strobe start");
  a_wr_data_hold: assert property ($past(wr_win) |-> $stable(data_bus))
    else $error("write data moved around the strobe");
  a_one_style: assert property (!(strobe_e && (!rd_n || !wr_n)) && (rd_n || wr_n))
    else $error("strobe styles mixed");
  a_strobe_width: assert property ($rose(wr_win) |-> wr_win [*3])
    else $error("write strobe too short to be seen");
endmodule : dphp_link_asserts

// ### display_parallel_host_port_tb.sv
// self-checking bench: host end and display end joined over the pin link
module display_parallel_host_port_tb
  import dphp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // short busy and guard counts keep the run brief
  localparam int BUSY_N = 20;
  localparam int GUARD_N = 20;
  logic i_clk;
  logic i_sys_rst;
  logic intel_mode;
  logic [6:0] cursor_pos;
  logic [7:0] read_data;
  logic rx_ready;
  logic hold_rx;
  logic req_valid;
  logic req_write;
  logic req_rs;
  logic [7:0] req_data;
  logic req_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic host_narrow;
  logic dev_busy;
  logic dev_narrow;
  logic read_done;
  logic rx_valid;
  logic rx_is_data;
  logic [7:0] rx_byte;
  logic busy_q;
  int rises;
  int dones;
  int fail_count;
  int compares;
  logic [8:0] exp_rx[$];
  logic [8:0] exp_rsp[$];

  dphp_if link();
  dphp_host_end #(.GUARD_CYC(GUARD_N)) dphp_host_end_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .bus(link), .i_intel_mode(intel_mode), .i_req_valid(req_valid),
    .i_req_write(req_write), .i_req_rs(req_rs), .i_req_data(req_data),
    .o_req_ready(req_ready), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_narrow(host_narrow));
  dphp_device_end #(.BUSY_CYC(BUSY_N), .FIFO_DEPTH(DPHP_FIFO_DEPTH)) dphp_device_end_inst (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(link), .i_intel_mode(intel_mode),
    .i_cursor_pos(cursor_pos), .i_read_data(read_data), .o_busy(dev_busy),
    .o_narrow(dev_narrow), .o_read_done(read_done), .o_rx_valid(rx_valid),
    .o_rx_is_data(rx_is_data), .o_rx_byte(rx_byte), .i_rx_ready(rx_ready));
  dphp_link_asserts #(.BUSY_CYC(BUSY_N)) dphp_link_asserts_inst (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .register_select(link.register_select), .rw(link.rw),
    .strobe_e(link.strobe_e), .rd_n(link.rd_n), .wr_n(link.wr_n), .host_oe(link.host_oe),
    .dev_oe(link.dev_oe), .busy(link.busy), .data_bus(link.data_bus));

  always #25 i_clk = ~i_clk;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic rs, input logic [7:0] d);
    req_valid <= 1'b1;
    req_write <= w;
    req_rs <= rs;
    req_data <= d;
    @(posedge i_clk);
    while (req_ready !== 1'b1) @(posedge i_clk);
    req_valid <= 1'b0;
    do @(posedge i_clk); while (req_ready !== 1'b1);
  endtask : xfer

  task automatic wr(input logic rs, input logic [7:0] d);
    exp_rx.push_back({rs, d});
    xfer(1'b1, rs, d);
  endtask : wr

  task automatic rd(input logic rs, input logic [7:0] e);
    exp_rsp.push_back({1'b0, e});
    xfer(1'b0, rs, 8'h00);
  endtask : rd

  task automatic conclude;
    $display("checks %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude

  // results are matched in order against the notes left by the driver
  always @(posedge i_clk)
  begin
    busy_q <= link.busy;
    rises <= rises + int'(link.busy && !busy_q);
    dones <= dones + int'(read_done === 1'b1);
    rx_ready <= hold_rx ? 1'b0 : 1'($urandom_range(0, 1));
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      chk({rx_is_data, rx_byte}, exp_rx.pop_front(), "rx byte");
    if (rsp_valid === 1'b1)
      chk({1'b0, rsp_data}, exp_rsp.pop_front(), "read word");
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] b;
    int base;
    int base_done;
    i_clk = 1'b0;
    i_sys_rst = 1'b1;
    {intel_mode, cursor_pos, read_data, hold_rx} = '0;
    {req_valid, req_write, req_rs, req_data} = '0;
    void'($urandom(14));
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    chk({7'h00, host_narrow, dev_narrow}, 9'h000, "width after reset");
    // passes: enable/separate strobe style crossed with wide/narrow width
    for (int p = 0; p < 4; p++)
    begin
      intel_mode <= p[0];
      repeat (4) @(posedge i_clk);
      base = rises;
      base_done = dones;
      if (p[1])
      begin
        wr(1'b0, DPHP_CMD_NARROW | 8'($urandom_range(0, 3)));
        repeat (4) @(posedge i_clk);
        chk({7'h00, host_narrow, dev_narrow}, 9'h003, "narrow entry");
      end
      for (int k = 0; k < 4; k++)
        wr(1'($urandom_range(0, 1)), 8'($urandom));
      b = 8'($urandom);
      cursor_pos <= b[6:0];
      rd(1'b0, {1'b0, b[6:0]});
      b = 8'($urandom);
      read_data <= b;
      rd(1'b1, b);
      if (p[1])
      begin
        wr(1'b0, DPHP_CMD_WIDE | 8'($urandom_range(0, 3)));
        repeat (4) @(posedge i_clk);
        chk({7'h00, host_narrow, dev_narrow}, 9'h000, "wide entry");
      end
      chk(9'(rises - base), p[1] ? 9'h006 : 9'h004, "busy count");
      chk(9'(dones - base_done), 9'h001, "read done count");
    end
    // fill the receive fifo with the core stalled, then drain it
    while (exp_rx.size() != 0) @(posedge i_clk);
    hold_rx <= 1'b1;
    for (int k = 0; k < DPHP_FIFO_DEPTH; k++)
      wr(1'b1, 8'($urandom));
    fork
      wr(1'b1, 8'h5a);
    join_none
    repeat (100) @(posedge i_clk);
    chk({6'h00, link.busy, dev_busy, req_ready}, 9'h006, "stall while full");
    hold_rx <= 1'b0;
    while (exp_rx.size() != 0) @(posedge i_clk);
    repeat (20) @(posedge i_clk);
    conclude();
  end

  initial
  begin
    repeat (40000) @(posedge i_clk);
    fail_count++;
    conclude();
  end
endmodule : display_parallel_host_port_tb
